//--- verilog/spisc_core.sv
// Purpose: Serial port with status flags, buffers, configuration and bus slave
// Assumes: Link pins asynchronous to clk; Avalon-MM master keeps requests stable
// Notes:   Standard mode uses one buffer slot, enhanced mode eight slots
// Behaviour
// - Master select bit chooses master or slave
// - Single buffer: write sets, shift load clears
// - FIFO: last slot fills sets, free slot clears
// - Single buffer: receive sets, CPU read clears
// - FIFO: last unread slot sets, free clears
// - Receive buffer full: drop new, set overflow
// - Interrupt select codes pick FIFO event
// - Clock pin disable releases master clock pin
// - Data-out disable releases serial output pin
// - Width bit picks 16 or 8 bits
// - Sample phase: end or middle in master
// - Edge bit picks data change transition
// - Polarity bit sets idle clock level
`timescale 1ns/100ps
module spisc_core (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt
  output logic             irq,
  // Serial pins
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  output logic             sdo_oe,
  input  wire logic        ss_n_i
);
  // ==========================================================
  // Declarations
  logic        en_ff, sidl_ff, rov_ff, clock_pin_disable_ff, dataout_pin_disable_ff, width_ff;
  logic        smp_ff, edge_ff, select_pin_enable_ff, cpol_ff, master_ff, enh_ff;
  logic [2:0]  fifo_irq_select_ff;
  logic [2:0]  irq_stat_ff, irq_mask_ff;
  logic        irq_ff, waitrequest_ff;
  logic [31:0] readdata_ff;
  logic [15:0] tx_mem [0:7];
  logic [15:0] rx_mem [0:7];
  logic [2:0]  tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
  logic [3:0]  tx_cnt_ff, rx_cnt_ff;
  logic        busy_ff;
  logic [7:0]  div_ff;
  logic [5:0]  half_ff;
  logic [4:0]  bit_ff;
  logic [15:0] tx_sr_ff, rx_sr_ff;
  logic        sck_o_ff, sck_oe_ff, sdo_ff, sdo_oe_ff;
  logic [2:0]  pin_meta_ff, pin_sync_ff;
  logic        sck_prev_ff;
  logic        acc, wr_data, rd_data, push_tx, pop_rx, tx_full, rx_full;
  logic [3:0]  cap;
  logic [4:0]  nbits;
  logic [5:0]  two_n;
  logic        tick, m_lead, m_trail, m_end, s_sel, s_lead, s_trail;
  logic        lead, trail, samp, shift, load, done, ovf_ev, fifo_cond;
  logic        sck_s, sdi_s, ss_n_s;
  logic [15:0] wmask, cur, merged, rx_word;
  logic [2:0]  nxt_irq_stat;
  logic [31:0] nxt_readdata;

  // ==========================================================
  // Pin synchronisers
  assign sck_s  = pin_sync_ff[0];
  assign sdi_s  = pin_sync_ff[1];
  assign ss_n_s = pin_sync_ff[2];

  // Two flip-flops per link input
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_meta_ff <= 3'h7;
      pin_sync_ff <= 3'h7;
      sck_prev_ff <= 1'b1;
    end
    else
    begin
      pin_meta_ff <= {ss_n_i, sdi_i, sck_i};
      pin_sync_ff <= pin_meta_ff;
      sck_prev_ff <= pin_sync_ff[0];
    end
  end

  // ==========================================================
  // Bus decode and buffer levels
  assign acc     = (avs_read | avs_write) & ~waitrequest_ff;
  assign wr_data = avs_write & acc & (avs_address == spisc_pkg::OFF_DATA);
  assign rd_data = avs_read & acc & (avs_address == spisc_pkg::OFF_DATA);
  assign cap     = enh_ff ? spisc_pkg::FIFO_DEPTH : spisc_pkg::STD_DEPTH;
  assign tx_full = (tx_cnt_ff >= cap);
  assign rx_full = (rx_cnt_ff >= cap);
  assign push_tx = wr_data & en_ff & ~tx_full;
  assign pop_rx  = rd_data & (rx_cnt_ff != 4'h0);
  assign wmask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign nbits   = width_ff ? spisc_pkg::BITS_WORD : spisc_pkg::BITS_BYTE;
  assign two_n   = {nbits, 1'b0};

  // ==========================================================
  // Shift events for master and slave
  assign tick    = master_ff & busy_ff & (div_ff == spisc_pkg::HALF_CYC - 8'h01);
  assign m_lead  = tick & (half_ff < two_n) & ~half_ff[0];
  assign m_trail = tick & (half_ff < two_n) & half_ff[0];
  assign m_end   = tick & (half_ff == two_n);
  assign s_sel   = ~select_pin_enable_ff | ~ss_n_s;
  assign s_lead  = ~master_ff & en_ff & s_sel & (sck_s != sck_prev_ff) & (sck_s != cpol_ff);
  assign s_trail = ~master_ff & en_ff & s_sel & (sck_s != sck_prev_ff) & (sck_s == cpol_ff);
  assign lead    = m_lead | s_lead;
  assign trail   = m_trail | s_trail;
  assign load    = en_ff & ~busy_ff & (tx_cnt_ff != 4'h0) & (master_ff | bit_ff == 5'h00);

  // Sample point and data change point
  always_comb
  begin
    if (master_ff & smp_ff)
      samp = edge_ff ? m_trail : ((m_lead & (half_ff != 6'h00)) | m_end);
    else
      samp = edge_ff ? lead : trail;
    if (edge_ff)
      shift = trail;
    else
      shift = lead & (master_ff ? (half_ff != 6'h00) : (bit_ff != 5'h00));
  end

  assign done    = master_ff ? m_end : (samp & (bit_ff == nbits - 5'h01));
  assign rx_word = width_ff ? (samp ? {rx_sr_ff[14:0], sdi_s} : rx_sr_ff)
                            : {8'h00, (samp ? {rx_sr_ff[6:0], sdi_s} : rx_sr_ff[7:0])};
  assign ovf_ev  = done & rx_full & ~pop_rx;

  // ==========================================================
  // Master divider and shift engine
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_ff  <= 1'b0;
      div_ff   <= 8'h00;
      half_ff  <= 6'h00;
      bit_ff   <= 5'h00;
      tx_sr_ff <= spisc_pkg::RST_WORD;
      rx_sr_ff <= spisc_pkg::RST_WORD;
    end
    else if (~en_ff)
    begin
      busy_ff <= 1'b0;
      div_ff  <= 8'h00;
      half_ff <= 6'h00;
      bit_ff  <= 5'h00;
    end
    else
    begin
      if (load)
      begin
        busy_ff  <= 1'b1;
        tx_sr_ff <= tx_mem[tx_rp_ff];
        div_ff   <= 8'h00;
        half_ff  <= 6'h00;
      end
      else
      begin
        if (shift)
          tx_sr_ff <= {tx_sr_ff[14:0], 1'b0};
        if (done)
          busy_ff <= 1'b0;
        if (master_ff & busy_ff)
          div_ff <= tick ? 8'h00 : div_ff + 8'h01;
        if (tick)
          half_ff <= half_ff + 6'h01;
      end
      if (samp)
        rx_sr_ff <= {rx_sr_ff[14:0], sdi_s};
      if (done | (~master_ff & ~s_sel))
        bit_ff <= 5'h00;
      else if (samp)
        bit_ff <= bit_ff + 5'h01;
    end
  end

  // ==========================================================
  // Transmit buffer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_wp_ff  <= 3'h0;
      tx_rp_ff  <= 3'h0;
      tx_cnt_ff <= 4'h0;
    end
    else if (~en_ff)
    begin
      tx_wp_ff  <= 3'h0;
      tx_rp_ff  <= 3'h0;
      tx_cnt_ff <= 4'h0;
    end
    else
    begin
      if (push_tx)
        tx_wp_ff <= enh_ff ? tx_wp_ff + 3'h1 : 3'h0;
      if (load)
        tx_rp_ff <= enh_ff ? tx_rp_ff + 3'h1 : 3'h0;
      tx_cnt_ff <= tx_cnt_ff + {3'h0, push_tx} - {3'h0, load};
    end
  end

  // Transmit storage
  always_ff @(posedge clk)
  begin
    if (push_tx)
      tx_mem[tx_wp_ff] <= avs_writedata[15:0];
  end

  // ==========================================================
  // Receive buffer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_wp_ff  <= 3'h0;
      rx_rp_ff  <= 3'h0;
      rx_cnt_ff <= 4'h0;
    end
    else if (~en_ff)
    begin
      rx_wp_ff  <= 3'h0;
      rx_rp_ff  <= 3'h0;
      rx_cnt_ff <= 4'h0;
    end
    else
    begin
      if (done & ~ovf_ev)
        rx_wp_ff <= enh_ff ? rx_wp_ff + 3'h1 : 3'h0;
      if (pop_rx)
        rx_rp_ff <= enh_ff ? rx_rp_ff + 3'h1 : 3'h0;
      rx_cnt_ff <= rx_cnt_ff + {3'h0, done & ~ovf_ev} - {3'h0, pop_rx};
    end
  end

  // Receive storage, new word dropped on overflow
  always_ff @(posedge clk)
  begin
    if (done & ~ovf_ev)
      rx_mem[rx_wp_ff] <= rx_word;
  end

  // ==========================================================
  // Configuration registers
  assign cur    = (avs_address == spisc_pkg::OFF_STATUS) ?
                  {en_ff, 1'b0, sidl_ff, 7'h00, fifo_irq_select_ff, 3'h0} :
                  {3'h0, clock_pin_disable_ff, dataout_pin_disable_ff, width_ff, smp_ff, edge_ff,
                   select_pin_enable_ff, cpol_ff, master_ff, 5'h00};
  assign merged = (avs_writedata[15:0] & wmask) | (cur & ~wmask);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      en_ff     <= spisc_pkg::RST_CFG[spisc_pkg::ST_EN];
      sidl_ff   <= spisc_pkg::RST_CFG[spisc_pkg::ST_SIDL];
      fifo_irq_select_ff  <= spisc_pkg::RST_CFG[spisc_pkg::ST_FIFO_IRQ_SELECT +: 3];
      clock_pin_disable_ff <= spisc_pkg::RST_CFG[spisc_pkg::C1_CLOCK_PIN_DISABLE];
      dataout_pin_disable_ff <= spisc_pkg::RST_CFG[spisc_pkg::C1_DATAOUT_PIN_DISABLE];
      width_ff  <= spisc_pkg::RST_CFG[spisc_pkg::C1_WIDTH];
      smp_ff    <= spisc_pkg::RST_CFG[spisc_pkg::C1_SMP];
      edge_ff   <= spisc_pkg::RST_CFG[spisc_pkg::C1_EDGE];
      select_pin_enable_ff   <= spisc_pkg::RST_CFG[spisc_pkg::C1_SELECT_PIN_ENABLE];
      cpol_ff   <= spisc_pkg::RST_CFG[spisc_pkg::C1_CPOL];
      master_ff <= spisc_pkg::RST_CFG[spisc_pkg::C1_MASTER];
      enh_ff    <= spisc_pkg::RST_CFG[spisc_pkg::BM_ENH];
    end
    else if (avs_write & acc)
    begin
      if (avs_address == spisc_pkg::OFF_STATUS)
      begin
        en_ff    <= merged[spisc_pkg::ST_EN];
        sidl_ff  <= merged[spisc_pkg::ST_SIDL];
        fifo_irq_select_ff <= merged[spisc_pkg::ST_FIFO_IRQ_SELECT +: 3];
      end
      if (avs_address == spisc_pkg::OFF_CTRL_ONE)
      begin
        clock_pin_disable_ff <= merged[spisc_pkg::C1_CLOCK_PIN_DISABLE];
        dataout_pin_disable_ff <= merged[spisc_pkg::C1_DATAOUT_PIN_DISABLE];
        width_ff  <= merged[spisc_pkg::C1_WIDTH];
        smp_ff    <= merged[spisc_pkg::C1_SMP];
        edge_ff   <= merged[spisc_pkg::C1_EDGE];
        select_pin_enable_ff   <= merged[spisc_pkg::C1_SELECT_PIN_ENABLE];
        cpol_ff   <= merged[spisc_pkg::C1_CPOL];
        master_ff <= merged[spisc_pkg::C1_MASTER];
      end
      if ((avs_address == spisc_pkg::OFF_BUF_MODE) & avs_byteenable[0])
        enh_ff <= avs_writedata[spisc_pkg::BM_ENH];
    end
  end

  // Overflow flag, set wins over a software clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rov_ff <= 1'b0;
    else if (ovf_ev)
      rov_ff <= 1'b1;
    else if (avs_write & acc & (avs_address == spisc_pkg::OFF_STATUS) & avs_byteenable[0]
             & ~avs_writedata[spisc_pkg::ST_ROV])
      rov_ff <= 1'b0;
  end

  // ==========================================================
  // Interrupt condition select
  always_comb
  begin
    fifo_cond = done;
    if (enh_ff)
    begin
      unique case (fifo_irq_select_ff)
        3'h7: fifo_cond = tx_full;
        3'h6: fifo_cond = load & (tx_cnt_ff == 4'h1);
        3'h5: fifo_cond = done & (tx_cnt_ff == 4'h0);
        3'h4: fifo_cond = load;
        3'h3: fifo_cond = rx_full;
        3'h2: fifo_cond = (rx_cnt_ff >= spisc_pkg::RX_3Q);
        3'h1: fifo_cond = (rx_cnt_ff != 4'h0);
        3'h0: fifo_cond = pop_rx & (rx_cnt_ff == 4'h1);
      endcase
    end
  end

  // Sticky status, write one clears, set wins
  always_comb
  begin
    nxt_irq_stat = irq_stat_ff;
    if (avs_write & acc & (avs_address == spisc_pkg::OFF_IRQ_STAT) & avs_byteenable[0])
      nxt_irq_stat = irq_stat_ff & ~avs_writedata[2:0];
    nxt_irq_stat[spisc_pkg::IRQ_FIFO] = nxt_irq_stat[spisc_pkg::IRQ_FIFO] | (en_ff & fifo_cond);
    nxt_irq_stat[spisc_pkg::IRQ_OVF]  = nxt_irq_stat[spisc_pkg::IRQ_OVF] | ovf_ev;
    nxt_irq_stat[spisc_pkg::IRQ_DONE] = nxt_irq_stat[spisc_pkg::IRQ_DONE] | done;
  end

  // Interrupt status, mask and output
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_stat_ff <= spisc_pkg::RST_IRQ;
      irq_mask_ff <= spisc_pkg::RST_IRQ;
      irq_ff      <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      if (avs_write & acc & (avs_address == spisc_pkg::OFF_IRQ_MASK) & avs_byteenable[0])
        irq_mask_ff <= avs_writedata[2:0];
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  // ==========================================================
  // Read data mux, prepared while waitrequest is high
  always_comb
  begin
    nxt_readdata = 32'h0000_0000;
    unique case (avs_address)
      spisc_pkg::OFF_STATUS:
        nxt_readdata[15:0] = {en_ff, 1'b0, sidl_ff, 2'h0,
                              (master_ff ? tx_cnt_ff[2:0] : rx_cnt_ff[2:0]),
                              ~busy_ff, rov_ff, (rx_cnt_ff == 4'h0), fifo_irq_select_ff,
                              tx_full, rx_full};
      spisc_pkg::OFF_CTRL_ONE:
        nxt_readdata[15:0] = cur;
      spisc_pkg::OFF_DATA:
        nxt_readdata[15:0] = rx_mem[rx_rp_ff];
      spisc_pkg::OFF_IRQ_STAT:
        nxt_readdata[2:0] = irq_stat_ff;
      spisc_pkg::OFF_IRQ_MASK:
        nxt_readdata[2:0] = irq_mask_ff;
      spisc_pkg::OFF_BUF_MODE:
        nxt_readdata[0] = enh_ff;
      default:
        nxt_readdata = 32'h0000_0000;
    endcase
  end

  // Bus handshake, one wait cycle per access
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      waitrequest_ff <= 1'b1;
      readdata_ff    <= 32'h0000_0000;
    end
    else
    begin
      waitrequest_ff <= ~((avs_read | avs_write) & waitrequest_ff);
      if (avs_read & waitrequest_ff)
        readdata_ff <= (avs_address == spisc_pkg::OFF_DATA & rx_cnt_ff == 4'h0) ?
                       32'h0000_0000 : nxt_readdata;
    end
  end

  // ==========================================================
  // Pin drivers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sck_o_ff  <= 1'b0;
      sck_oe_ff <= 1'b0;
      sdo_ff    <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end
    else
    begin
      if (~busy_ff | ~master_ff | load)
        sck_o_ff <= cpol_ff;
      else if (m_lead | m_trail)
        sck_o_ff <= ~sck_o_ff;
      sck_oe_ff <= en_ff & master_ff & ~clock_pin_disable_ff;
      sdo_ff    <= width_ff ? tx_sr_ff[15] : tx_sr_ff[7];
      sdo_oe_ff <= en_ff & ~dataout_pin_disable_ff & (master_ff | s_sel);
    end
  end

  assign avs_readdata    = readdata_ff;
  assign avs_waitrequest = waitrequest_ff;
  assign irq             = irq_ff;
  assign sck_o           = sck_o_ff;
  assign sck_oe          = sck_oe_ff;
  assign sdo_o           = sdo_ff;
  assign sdo_oe          = sdo_oe_ff;
endmodule

//--- common/spisc_pkg.sv
// Purpose: Shared constants of the serial port status and configuration block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, 100 MHz clock
// Notes:   Offsets are byte addresses; every register takes one aligned word
package spisc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [4:0] OFF_STATUS   = 5'h00;
  localparam logic [4:0] OFF_CTRL_ONE = 5'h04;
  localparam logic [4:0] OFF_DATA     = 5'h08;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h0C;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
  localparam logic [4:0] OFF_BUF_MODE = 5'h14;
  // ==========================================================
  // Status and control field positions
  localparam int ST_EN    = 15;
  localparam int ST_SIDL  = 13;
  localparam int ST_BEC   = 8;
  localparam int ST_SHIFT_REG_EMPTY_FLAG = 7;
  localparam int ST_ROV   = 6;
  localparam int ST_RXMPT = 5;
  localparam int ST_FIFO_IRQ_SELECT = 2;
  localparam int ST_TBF   = 1;
  localparam int ST_RBF   = 0;
  // ==========================================================
  // Control one field positions
  localparam int C1_CLOCK_PIN_DISABLE = 12;
  localparam int C1_DATAOUT_PIN_DISABLE = 11;
  localparam int C1_WIDTH  = 10;
  localparam int C1_SMP    = 9;
  localparam int C1_EDGE   = 8;
  localparam int C1_SELECT_PIN_ENABLE   = 7;
  localparam int C1_CPOL   = 6;
  localparam int C1_MASTER = 5;
  // ==========================================================
  // Interrupt status bits and buffer mode bit
  localparam int IRQ_FIFO = 0;
  localparam int IRQ_OVF  = 1;
  localparam int IRQ_DONE = 2;
  localparam int BM_ENH   = 0;
  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_CFG  = 16'h0000;
  localparam logic [2:0]  RST_IRQ  = 3'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // ==========================================================
  // Buffer sizes
  localparam logic [3:0] FIFO_DEPTH = 4'h8;
  localparam logic [3:0] STD_DEPTH  = 4'h1;
  localparam logic [3:0] RX_3Q      = 4'h6;
  localparam logic [4:0] BITS_WORD  = 5'h10;
  localparam logic [4:0] BITS_BYTE  = 5'h08;
  // ==========================================================
  // Master shift clock timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_HALF_NS   = 40;
  localparam int HALF_CYC_INT  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] HALF_CYC = 8'(HALF_CYC_INT);
endpackage

//--- testbench/spisc_core_asserts.sv
// Purpose: Port-level checks of the serial port status and configuration block
// Assumes: One clock domain, sys_rst asynchronous and active high
// Notes:   Bound to every spisc_core instance
`timescale 1ns/100ps
module spisc_core_asserts (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register bus
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // Interrupt and serial pins
  input  wire logic        irq,
  input  wire logic        sck_i,
  input  wire logic        sck_o,
  input  wire logic        sck_oe,
  input  wire logic        sdi_i,
  input  wire logic        sdo_o,
  input  wire logic        sdo_oe,
  input  wire logic        ss_n_i
);
  // ==========================================================
  // Accepted writes by target
  logic wr_ok;
  logic ctl_wr;
  logic sts_wr;
  assign wr_ok  = avs_write && !avs_waitrequest;
  assign ctl_wr = wr_ok && avs_address == spisc_pkg::OFF_CTRL_ONE && avs_byteenable[1];
  assign sts_wr = wr_ok && avs_address == spisc_pkg::OFF_STATUS && avs_byteenable[1];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Bus handshake and pin control
  chk_wait_single:
    assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_wait_answer:
    assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  chk_clk_pin_off:
    assert property (ctl_wr && avs_writedata[12] |-> ##2 !sck_oe)
    else $error("clock pin still driven after disable");
  chk_dout_pin_off:
    assert property (ctl_wr && avs_writedata[11] |-> ##2 !sdo_oe)
    else $error("data out pin still driven after disable");
  chk_slave_no_clk:
    assert property (ctl_wr && !avs_writedata[5] |-> ##2 !sck_oe)
    else $error("slave drives the clock pin");
  chk_port_release:
    assert property (sts_wr && !avs_writedata[15] |-> ##2 (!sck_oe && !sdo_oe))
    else $error("pins kept after port disable");
  chk_irq_masked:
    assert property (wr_ok && avs_address == spisc_pkg::OFF_IRQ_MASK && avs_byteenable[0]
                     && avs_writedata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("interrupt high with all sources masked");
  chk_sck_half:
    assert property (sck_oe && $changed(sck_o) |=> $stable(sck_o) [*3])
    else $error("shift clock half period shorter than four cycles");
endmodule
bind spisc_core spisc_core_asserts u_chk (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi_i), .sdo_o(sdo_o),
  .sdo_oe(sdo_oe), .ss_n_i(ss_n_i)
);

//--- testbench/spisc_far_master.sv
// Purpose: Far-side serial master driving clock, select and data pins
// Assumes: Edge bit clear on the port; 125 ns link clock period
// Notes:   Clock stands at idle level between frames
`timescale 1ns/100ps
module spisc_far_master (
  // Link pins
  output logic       sck,
  output logic       sdi,
  output logic       ss_n,
  input  wire logic  sdo,
  // Setup
  input  wire logic  cpol
);
  logic       act;
  logic [7:0] got;
  // ==========================================================
  // Clock level from polarity and active phase
  assign sck = cpol ^ act;
  initial
  begin
    act  = 1'b0;
    sdi  = 1'b0;
    ss_n = 1'b1;
    got  = 8'h00;
  end
  // ==========================================================
  // One byte frame, MSB first; data moves on idle to active
  task automatic xfer(input logic [7:0] w, input logic sel);
    ss_n = !sel;
    #62.5;
    for (int i = 7; i >= 0; i--)
    begin
      act = 1'b1;
      sdi = w[i];
      #62.5;
      act = 1'b0;
      got = {got[6:0], sdo};
      #62.5;
    end
    ss_n = 1'b1;
    sdi  = ~sdi;
  endtask
endmodule

//--- testbench/spi_status_and_config_tb_top.sv
// Purpose: Self-checking bench of the serial port status and configuration block
// Assumes: Loopback of data out to data in while the port is master
// Notes:   Far-side master model drives the pins in slave tests
`timescale 1ns/100ps
module spi_status_and_config_tb_top;
  // ==========================================================
  // Signals
  logic        clk;
  logic        sys_rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        sck_o;
  logic        sck_oe;
  logic        sdo_o;
  logic        sdo_oe;
  logic        sdi_i;
  logic        p_sck;
  logic        p_sdi;
  logic        p_ss_n;
  logic        cpol;
  logic        loop_on;
  logic [15:0] rdv;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  // Clock and data-in source
  always #5 clk = ~clk;
  assign sdi_i = loop_on ? sdo_o : p_sdi;
  // ==========================================================
  // Design and far side
  spisc_core DUT (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .sck_i(p_sck), .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi_i), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe), .ss_n_i(p_ss_n)
  );
  spisc_far_master far (.sck(p_sck), .sdi(p_sdi), .ss_n(p_ss_n), .sdo(sdo_o), .cpol(cpol));
  // ==========================================================
  // Verdict and hang guard
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test();
    end
  end
  // ==========================================================
  // Compare, bus access and waits
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_read      <= !w;
    avs_write     <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rdv = avs_readdata[15:0];
    chk("rd_upper", avs_readdata[31:16], 16'h0000);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] e, input string nm);
    bus(1'b0, a, 16'h0000);
    chk(nm, rdv, e);
  endtask
  task automatic rb(input int b, input logic e, input string nm);
    bus(1'b0, spisc_pkg::OFF_STATUS, 16'h0000);
    chk(nm, {15'h0000, rdv[b]}, {15'h0000, e});
  endtask
  task automatic pin(input int s, input logic e, input string nm);
    repeat (2) @(negedge clk);
    chk(nm, {15'h0000, (s == 0 ? sck_oe : (s == 1 ? sck_o : sdo_oe))}, {15'h0000, e});
  endtask
  task automatic wirq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    chk("irq_rise", {15'h0000, irq}, 16'h0001);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    clk            = 1'b0;
    sys_rst        = 1'b1;
    avs_address    = 5'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h00000000;
    avs_byteenable = 4'hF;
    cpol           = 1'b0;
    loop_on        = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rc(spisc_pkg::OFF_CTRL_ONE, 16'h0000, "ctrl_rst");
    rc(spisc_pkg::OFF_IRQ_MASK, 16'h0000, "mask_rst");
    rc(5'h18, 16'h0000, "unmapped");
    // Master, single buffer, byte words, overflow
    bus(1'b1, spisc_pkg::OFF_IRQ_MASK, 16'h0004);
    bus(1'b1, spisc_pkg::OFF_CTRL_ONE, 16'h0020);
    bus(1'b1, spisc_pkg::OFF_STATUS, 16'h8000);
    pin(0, 1'b1, "sck_drive");
    chk("sdo_drive", {15'h0000, sdo_oe}, 16'h0001);
    bus(1'b1, spisc_pkg::OFF_DATA, 16'hA5C3);
    bus(1'b1, spisc_pkg::OFF_DATA, 16'h1234);
    rb(spisc_pkg::ST_TBF, 1'b1, "tbf_set");
    wirq();
    rb(spisc_pkg::ST_RBF, 1'b1, "rbf_set");
    rb(spisc_pkg::ST_TBF, 1'b0, "tbf_clr");
    bus(1'b1, spisc_pkg::OFF_IRQ_STAT, 16'h0005);
    rc(spisc_pkg::OFF_IRQ_STAT, 16'h0000, "irq_w1c");
    wirq();
    rc(spisc_pkg::OFF_IRQ_STAT, 16'h0007, "ovf_event");
    rc(spisc_pkg::OFF_DATA, 16'h00C3, "rx_byte");
    rb(spisc_pkg::ST_RBF, 1'b0, "rbf_clr");
    rc(spisc_pkg::OFF_DATA, 16'h0000, "rx_empty");
    rb(spisc_pkg::ST_ROV, 1'b1, "rov_hold");
    bus(1'b1, spisc_pkg::OFF_STATUS, 16'h8000);
    rb(spisc_pkg::ST_ROV, 1'b0, "rov_clr");
    bus(1'b1, spisc_pkg::OFF_IRQ_STAT, 16'h0007);
    // Sixteen-bit words
    bus(1'b1, spisc_pkg::OFF_CTRL_ONE, 16'h0420);
    bus(1'b1, spisc_pkg::OFF_DATA, 16'hA5C3);
    wirq();
    rc(spisc_pkg::OFF_DATA, 16'hA5C3, "rx_word");
    bus(1'b1, spisc_pkg::OFF_IRQ_STAT, 16'h0005);
    bus(1'b1, spisc_pkg::OFF_IRQ_MASK, 16'h0000);
    // Pin disables, idle polarity, port disable
    bus(1'b1, spisc_pkg::OFF_CTRL_ONE, 16'h1820);
    pin(0, 1'b0, "sck_off");
    chk("sdo_off", {15'h0000, sdo_oe}, 16'h0000);
    bus(1'b1, spisc_pkg::OFF_CTRL_ONE, 16'h0060);
    pin(1, 1'b1, "sck_idle_hi");
    bus(1'b1, spisc_pkg::OFF_STATUS, 16'h0000);
    pin(0, 1'b0, "port_off");
    // Interrupt select codes
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, spisc_pkg::OFF_STATUS, {11'h000, 3'(c), 2'h0});
      rc(spisc_pkg::OFF_STATUS, {8'h00, 3'b101, 3'(c), 2'h0}, "irq_sel");
    end
    // Eight-deep buffers, receive full event
    bus(1'b1, spisc_pkg::OFF_CTRL_ONE, 16'h0020);
    bus(1'b1, spisc_pkg::OFF_BUF_MODE, 16'h0001);
    bus(1'b1, spisc_pkg::OFF_STATUS, 16'h800C);
    bus(1'b1, spisc_pkg::OFF_IRQ_MASK, 16'h0001);
    for (int i = 0; i < 9; i++)
      bus(1'b1, spisc_pkg::OFF_DATA, 16'h0010 + 16'(i));
    rb(spisc_pkg::ST_TBF, 1'b1, "fifo_tbf");
    repeat (80) @(negedge clk);
    rb(spisc_pkg::ST_TBF, 1'b0, "fifo_tbf_clr");
    chk("elem_count", {13'h0000, rdv[10:8]}, 16'h0007);
    wirq();
    rb(spisc_pkg::ST_RBF, 1'b1, "fifo_rbf");
    rc(spisc_pkg::OFF_DATA, 16'h0010, "fifo_rx0");
    rb(spisc_pkg::ST_RBF, 1'b0, "fifo_rbf_clr");
    bus(1'b1, spisc_pkg::OFF_STATUS, 16'h0000);
    bus(1'b1, spisc_pkg::OFF_BUF_MODE, 16'h0000);
    bus(1'b1, spisc_pkg::OFF_IRQ_STAT, 16'h0007);
    // Slave with select pin gating
    loop_on <= 1'b0;
    bus(1'b1, spisc_pkg::OFF_CTRL_ONE, 16'h0080);
    bus(1'b1, spisc_pkg::OFF_STATUS, 16'h8000);
    bus(1'b1, spisc_pkg::OFF_IRQ_MASK, 16'h0004);
    bus(1'b1, spisc_pkg::OFF_DATA, 16'h005A);
    pin(2, 1'b0, "ss_gate");
    far.xfer(8'h3C, 1'b0);
    rb(spisc_pkg::ST_RBF, 1'b0, "ss_ignore");
    far.xfer(8'h96, 1'b1);
    wirq();
    rc(spisc_pkg::OFF_DATA, 16'h0096, "slave_rx");
    chk("slave_tx", {8'h00, far.got}, 16'h005A);
    finish_test();
  end
endmodule
